/* vsir_pkg.sv */
package vsir_pkg;

   // Register byte offsets on the APB port
   localparam logic [7:0] OFF_CLK_CTRL  = 8'h00;
   localparam logic [7:0] OFF_IRQ_SEL_B = 8'h04;
   localparam logic [7:0] OFF_IRQ_SEL_C = 8'h08;
   localparam logic [7:0] OFF_EVT_SEL   = 8'h0C;
   localparam logic [7:0] OFF_MEM_PRIO  = 8'h10;

   // Writable-bit masks; all other bits read as zero
   localparam logic [31:0] SEL4_MASK     = 32'h1F1F1F1F;
   localparam logic [31:0] SEL1_MASK     = 32'h0000001F;
   localparam logic [31:0] PRIO_MASK     = 32'h011FFFFE;
   localparam logic [31:0] CLK_CTRL_MASK = 32'h000000DD;

   // Reset values
   localparam logic [31:0] SEL_RST      = 32'h00000000;
   localparam logic [31:0] PRIO_RST     = 32'h00000000;
   localparam logic [31:0] CLK_CTRL_RST = 32'h00000019;

   // Field positions
   localparam int SEL_W         = 5;
   localparam int SEL_STRIDE    = 8;
   localparam int RGB_COPY_BIT  = 24;
   localparam int PRIO_HI_BIT   = 20;
   localparam int PRIO_LO_BIT   = 4;
   localparam int LIN_PRIO_BIT  = 1;
   localparam int SHADE1_BIT    = 3;
   localparam int SHADE0_BIT    = 2;
   localparam int LDC_OWNER_BIT = 7;
   localparam int OVL_OWNER_BIT = 6;
   localparam int LDC_GATE_BIT  = 3;
   localparam int ENC_HALF_BIT  = 2;
   localparam int BE_GATE_BIT   = 0;

   // Source code space
   localparam int NUM_SRC        = 30;
   localparam logic [31:0] RSVD_CODES = 32'hC00C9040;

   typedef struct packed {
      logic lens_distortion_mem_owner;
      logic overlay_mem_owner;
      logic lens_distortion_clk_gate;
      logic encoder_clk_halve;
      logic backend_clk_gate;
   } vsir_clk_ctl_t;

   typedef struct packed {
      logic        rgb_table_copy_en;
      logic [16:0] table_prio;
      logic        shading_table1_select;
      logic        shading_table0_select;
      logic        linearization_table_prio;
   } vsir_mem_ctl_t;

endpackage

/* vsir_route.sv */
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
// Overview of operation
// - Second irq-select register: sources for outputs 7,6,5,4 at 28-24,20-16,12-8,4-0.
// - Third irq-select register: output 8 source in bits 4-0, rest reserved.
// - Event-select register: event 0..3 sources at 4-0,12-8,20-16,28-24.
// - Event codes 0..29 follow status order; 6,12,15,18,19,30,31 reserved.
// - Irq select codes decode to the same source list as events.
// - Priority register bit 24 enables RGB table copy.
// - Priority bits 20..4 and 1, reset 0; bits 0, 23-21 reserved.
// - Bits 3 and 2 are shading table memory-access selects, reset 0.
// - Clock control bit 7: lens-distortion memory to host when 1.
// - Clock control bit 6: overlay memory to host when 1.
// - Bit 3 gates lens clock, bit 0 overlay/encoder, bit 2 halves encoder.
// - Clock control register sits at offset 0.
// - Reserved fields read zero except clock control bit 4, writable and reset 1; defined fields take reset values.
module vsir_route #(
   parameter int NUM_IRQ = 5,
   parameter int NUM_EVT = 4
) (
   // APB slave
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [7:0]                 paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   // Interrupt sources
   input  wire logic [vsir_pkg::NUM_SRC-1:0] irq_src,
   input  wire logic                       encoder_source_clock,
   // Routed outputs: irq 4..8, events 0..3
   output logic      [NUM_IRQ-1:0]         irq_out,
   output logic      [NUM_EVT-1:0]         evt_out,
   // Back-end control
   output vsir_pkg::vsir_clk_ctl_t         clk_ctl,
   output vsir_pkg::vsir_mem_ctl_t         mem_ctl,
   output logic                            encoder_clk_en
);

   // Register file, current and next values
   logic [31:0]                        irq_b_r;
   logic [31:0]                        irq_b_nxt;
   logic [31:0]                        irq_c_r;
   logic [31:0]                        irq_c_nxt;
   logic [31:0]                        evt_r;
   logic [31:0]                        evt_nxt;
   logic [31:0]                        prio_r;
   logic [31:0]                        prio_nxt;
   logic [31:0]                        cctl_r;
   logic [31:0]                        cctl_nxt;

   // Bus decode and answer
   logic                               access;
   logic                               done;
   logic                               hit;
   logic [31:0]                        rd_word;
   logic                               wr_irq_b;
   logic                               wr_irq_c;
   logic                               wr_evt;
   logic                               wr_prio;
   logic                               wr_cctl;
   logic [31:0]                        prdata_nxt;
   logic                               pready_nxt;
   logic                               pslverr_nxt;

   // Routing
   logic [31:0]                        src_live;
   logic [NUM_IRQ*vsir_pkg::SEL_W-1:0] irq_codes;
   logic [NUM_IRQ-1:0]                 irq_nxt;
   logic [NUM_EVT-1:0]                 evt_nxt_o;

   // Control outputs and encoder pacing
   vsir_pkg::vsir_clk_ctl_t            clk_ctl_nxt;
   vsir_pkg::vsir_mem_ctl_t            mem_ctl_nxt;
   logic                               half_r;
   logic                               half_nxt;
   logic                               enc_en_nxt;

   // Select fields per register, one every stride bits
   localparam int SEL_PER_REG = $bits(irq_b_r) / vsir_pkg::SEL_STRIDE;

   genvar gi;

   // Access phase before the answer; done marks the edge that completes a
   // transfer, the only edge at which the master promises to hold everything
   assign access = psel && penable && !pready;
   assign done   = psel && penable && pready;

   // Writes land only at the completing edge, never while the access still waits;
   // an unmapped address raises no strobe, so the write is dropped
   assign wr_irq_b = done && pwrite && (paddr == vsir_pkg::OFF_IRQ_SEL_B);
   assign wr_irq_c = done && pwrite && (paddr == vsir_pkg::OFF_IRQ_SEL_C);
   assign wr_evt   = done && pwrite && (paddr == vsir_pkg::OFF_EVT_SEL);
   assign wr_prio  = done && pwrite && (paddr == vsir_pkg::OFF_MEM_PRIO);
   assign wr_cctl  = done && pwrite && (paddr == vsir_pkg::OFF_CLK_CTRL);

   // Select register next values; masks drop reserved bits so they read zero
   // even when software is careless about them
   always_comb begin
      irq_b_nxt = irq_b_r;
      irq_c_nxt = irq_c_r;
      evt_nxt   = evt_r;
      if (wr_irq_b) begin
         irq_b_nxt = pwdata & vsir_pkg::SEL4_MASK;
      end
      if (wr_irq_c) begin
         irq_c_nxt = pwdata & vsir_pkg::SEL1_MASK;
      end
      if (wr_evt) begin
         evt_nxt = pwdata & vsir_pkg::SEL4_MASK;
      end
   end

   // Select register flops; all routes start on code zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_b_r <= vsir_pkg::SEL_RST;
         irq_c_r <= vsir_pkg::SEL_RST;
         evt_r   <= vsir_pkg::SEL_RST;
      end else begin
         irq_b_r <= irq_b_nxt;
         irq_c_r <= irq_c_nxt;
         evt_r   <= evt_nxt;
      end
   end

   // Control register next values; same masking as the selects
   always_comb begin
      prio_nxt = prio_r;
      cctl_nxt = cctl_r;
      if (wr_prio) begin
         prio_nxt = pwdata & vsir_pkg::PRIO_MASK;
      end
      if (wr_cctl) begin
         cctl_nxt = pwdata & vsir_pkg::CLK_CTRL_MASK;
      end
   end

   // Control register flops; clock control leaves reset with both gates open,
   // so the back end runs before software touches anything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio_r <= vsir_pkg::PRIO_RST;
         cctl_r <= vsir_pkg::CLK_CTRL_RST;
      end else begin
         prio_r <= prio_nxt;
         cctl_r <= cctl_nxt;
      end
   end

   // Read decode; an unmapped address reads zero and is answered with an error
   // rather than aliasing onto a real register
   always_comb begin
      hit     = 1'b1;
      rd_word = '0;
      unique case (paddr)
         vsir_pkg::OFF_CLK_CTRL:  rd_word = cctl_r;
         vsir_pkg::OFF_IRQ_SEL_B: rd_word = irq_b_r;
         vsir_pkg::OFF_IRQ_SEL_C: rd_word = irq_c_r;
         vsir_pkg::OFF_EVT_SEL:   rd_word = evt_r;
         vsir_pkg::OFF_MEM_PRIO:  rd_word = prio_r;
         default:                 hit     = 1'b0;
      endcase
   end

   // Slave answer: one wait state; prdata is loaded while the access waits,
   // so it stands at the completing edge and holds until the next read
   always_comb begin
      pready_nxt  = access;
      pslverr_nxt = access && !hit;
      prdata_nxt  = prdata;
      if (access && !pwrite) begin
         prdata_nxt = rd_word;
      end
   end

   // Answer flops; pready is a one-cycle pulse, so done never repeats a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= prdata_nxt;
         pready  <= pready_nxt;
         pslverr <= pslverr_nxt;
      end
   end

   // Reserved codes and codes past the last source pick a bit held low, which
   // also keeps every select index inside the vector
   assign src_live = 32'(irq_src) & ~vsir_pkg::RSVD_CODES;

   // Gather the irq select fields: register B carries outputs 4..7 in its four
   // slots, register C carries output 8 in its lowest slot
   generate
      for (gi = 0; gi < NUM_IRQ; gi++) begin : g_code
         if (gi < SEL_PER_REG) begin : g_b
            assign irq_codes[gi*vsir_pkg::SEL_W +: vsir_pkg::SEL_W] =
               irq_b_r[gi*vsir_pkg::SEL_STRIDE +: vsir_pkg::SEL_W];
         end else begin : g_c
            assign irq_codes[gi*vsir_pkg::SEL_W +: vsir_pkg::SEL_W] =
               irq_c_r[(gi-SEL_PER_REG)*vsir_pkg::SEL_STRIDE +: vsir_pkg::SEL_W];
         end
      end
   endgenerate

   // Per-channel source mux; each channel reads only its own field, so a write
   // to one select cannot disturb the other channels
   generate
      for (gi = 0; gi < NUM_IRQ; gi++) begin : g_irq
         logic [vsir_pkg::SEL_W-1:0] code;
         assign code        = irq_codes[gi*vsir_pkg::SEL_W +: vsir_pkg::SEL_W];
         assign irq_nxt[gi] = src_live[code];
      end
      for (gi = 0; gi < NUM_EVT; gi++) begin : g_evt
         logic [vsir_pkg::SEL_W-1:0] code;
         assign code          = evt_r[gi*vsir_pkg::SEL_STRIDE +: vsir_pkg::SEL_W];
         assign evt_nxt_o[gi] = src_live[code];
      end
   endgenerate

   // Routed outputs; a new select shows one cycle after its write lands, and
   // the flop hides any mux settling while the select changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_out <= '0;
         evt_out <= '0;
      end else begin
         irq_out <= irq_nxt;
         evt_out <= evt_nxt_o;
      end
   end

   // Control outputs mirror register fields one to one
   always_comb begin
      clk_ctl_nxt.lens_distortion_mem_owner = cctl_r[vsir_pkg::LDC_OWNER_BIT];
      clk_ctl_nxt.overlay_mem_owner         = cctl_r[vsir_pkg::OVL_OWNER_BIT];
      clk_ctl_nxt.lens_distortion_clk_gate  = cctl_r[vsir_pkg::LDC_GATE_BIT];
      clk_ctl_nxt.encoder_clk_halve         = cctl_r[vsir_pkg::ENC_HALF_BIT];
      clk_ctl_nxt.backend_clk_gate          = cctl_r[vsir_pkg::BE_GATE_BIT];
      mem_ctl_nxt.rgb_table_copy_en         = prio_r[vsir_pkg::RGB_COPY_BIT];
      mem_ctl_nxt.table_prio = prio_r[vsir_pkg::PRIO_HI_BIT:vsir_pkg::PRIO_LO_BIT];
      mem_ctl_nxt.shading_table1_select     = prio_r[vsir_pkg::SHADE1_BIT];
      mem_ctl_nxt.shading_table0_select     = prio_r[vsir_pkg::SHADE0_BIT];
      mem_ctl_nxt.linearization_table_prio  = prio_r[vsir_pkg::LIN_PRIO_BIT];
   end

   // Control flops; registered so the clock gates and memory owners never
   // see a decode glitch during a bus write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_ctl <= '0;
         mem_ctl <= '0;
      end else begin
         clk_ctl <= clk_ctl_nxt;
         mem_ctl <= mem_ctl_nxt;
      end
   end

   // Encoder pacing: enable every cycle, or every other cycle when halved; the
   // toggle restarts from zero whenever halving is off. The encoder clock pin
   // itself is divided outside; this only shows the rate it should run at
   always_comb begin
      half_nxt   = cctl_r[vsir_pkg::ENC_HALF_BIT] ? !half_r : 1'b0;
      enc_en_nxt = cctl_r[vsir_pkg::BE_GATE_BIT] &&
                   (!cctl_r[vsir_pkg::ENC_HALF_BIT] || !half_r);
   end

   // Encoder pacing flops; enable is low in reset until the gate is seen open
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         half_r         <= 1'b0;
         encoder_clk_en <= 1'b0;
      end else begin
         half_r         <= half_nxt;
         encoder_clk_en <= enc_en_nxt;
      end
   end

endmodule

/* vsir_route_monitor.sv */
`timescale 1ns/1ns
// Watches the APB port and routed outputs
module vsir_route_monitor #(
   parameter int NUM_IRQ = 5,
   parameter int NUM_EVT = 4
) (
   // Clock and reset
   input wire logic                           pclk,
   input wire logic                           presetn,
   // APB
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic                           pwrite,
   input wire logic [7:0]                     paddr,
   input wire logic [31:0]                    pwdata,
   input wire logic [31:0]                    prdata,
   input wire logic                           pready,
   input wire logic                           pslverr,
   // Routing and control
   input wire logic [vsir_pkg::NUM_SRC-1:0]   irq_src,
   input wire logic [NUM_IRQ-1:0]             irq_out,
   input wire logic [NUM_EVT-1:0]             evt_out,
   input wire vsir_pkg::vsir_clk_ctl_t        clk_ctl,
   input wire logic                           encoder_clk_en
);
   logic mapped;

   // Only the five register words answer without error
   assign mapped = paddr inside {vsir_pkg::OFF_CLK_CTRL, vsir_pkg::OFF_IRQ_SEL_B,
                                 vsir_pkg::OFF_IRQ_SEL_C, vsir_pkg::OFF_EVT_SEL,
                                 vsir_pkg::OFF_MEM_PRIO};

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_wait: assert property (psel && penable && !pready |-> ##[1:2] pready)
      else $error("access not answered");
   a_err_unmapped: assert property (pready && !pwrite && !mapped
      |-> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
   a_err_mapped: assert property (pready && mapped |-> !pslverr)
      else $error("mapped access refused");
   a_evt_rsvd_zero: assert property (pready && !pwrite && paddr == vsir_pkg::OFF_EVT_SEL
      |-> (prdata & ~vsir_pkg::SEL4_MASK) == 32'h0) else $error("event reserved bits set");
   a_prio_rsvd_zero: assert property (pready && !pwrite && paddr == vsir_pkg::OFF_MEM_PRIO
      |-> (prdata & ~vsir_pkg::PRIO_MASK) == 32'h0) else $error("prio reserved bits set");
   // Owner, gate and halve bits follow the clock control write
   a_clk_write: assert property (pready && pwrite && paddr == vsir_pkg::OFF_CLK_CTRL |=> ##1
      clk_ctl == {$past(pwdata[7], 2), $past(pwdata[6], 2), $past(pwdata[3], 2),
      $past(pwdata[2], 2), $past(pwdata[0], 2)}) else $error("clock control not applied");
   a_enc_gated: assert property (!clk_ctl.backend_clk_gate [*2] |-> !encoder_clk_en)
      else $error("encoder clock runs while gated");
   a_enc_half: assert property ((clk_ctl.backend_clk_gate && clk_ctl.encoder_clk_halve) [*3]
      |-> encoder_clk_en != $past(encoder_clk_en)) else $error("encoder not at half rate");
   a_src_quiet: assert property (irq_src == '0 [*2] |-> irq_out == '0 && evt_out == '0)
      else $error("output active with no source");
endmodule
bind vsir_route vsir_route_monitor #(.NUM_IRQ(NUM_IRQ), .NUM_EVT(NUM_EVT)) i_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .irq_src(irq_src), .irq_out(irq_out), .evt_out(evt_out), .clk_ctl(clk_ctl),
   .encoder_clk_en(encoder_clk_en));

/* test_vsir_route.sv */
`timescale 1ns/1ns
// Directed register and routing checks
module test_vsir_route;
   logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, en, err, h;
   logic [7:0]              paddr;
   logic [31:0]             pwdata, prdata, rd;
   logic [29:0]             irq_src;
   logic [4:0]              irq_out;
   logic [3:0]              evt_out;
   vsir_pkg::vsir_clk_ctl_t clk_ctl;
   vsir_pkg::vsir_mem_ctl_t mem_ctl;
   int                      n_mismatch = 0;
   int                      n_tests = 0;

   vsir_route i_vsir_route (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_src(irq_src), .encoder_source_clock(1'b0), .irq_out(irq_out),
      .evt_out(evt_out), .clk_ctl(clk_ctl), .mem_ctl(mem_ctl), .encoder_clk_en(en));

   // 250 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One APB transfer, then an idle cycle so no signal is driven twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, e);
      apb(1'b1, a, d);
      apb(1'b0, a, 32'h0);
      chk("readback", e, rd);
   endtask

   // Sources take one cycle, so outputs are judged a few edges later
   task automatic route(input logic [29:0] s, input logic [4:0] ei, input logic [3:0] ee);
      irq_src <= s;
      repeat (3) @(posedge pclk);
      chk("irq_out", ei, irq_out);
      chk("evt_out", ee, evt_out);
   endtask

   task automatic t_reset;
      chk("clk_ctl", 32'h05, clk_ctl);
      apb(1'b0, vsir_pkg::OFF_CLK_CTRL, 32'h0);
      chk("clock control reset", 32'h19, rd);
      for (int i = 1; i < 5; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk("reset value", 32'h0, rd);
      end
      $display("test reset done");
   endtask

   task automatic t_irq;
      wr_rd(vsir_pkg::OFF_IRQ_SEL_B, 32'h1F1D0E05, 32'h1F1D0E05);
      route('1, 5'h17, 4'hF);
      route(30'h4000, 5'h02, 4'h0);
      route(30'h20000000, 5'h04, 4'h0);
      wr_rd(vsir_pkg::OFF_IRQ_SEL_C, 32'h0000001C, 32'h1C);
      route(30'h10000000, 5'h10, 4'h0);
      $display("test irq done");
   endtask

   task automatic t_evt;
      wr_rd(vsir_pkg::OFF_EVT_SEL, 32'h06131D00, 32'h06131D00);
      route('1, 5'h17, 4'h3);
      route(30'h1, 5'h00, 4'h1);
      route(30'h40, 5'h00, 4'h0);
      route(30'h0, 5'h00, 4'h0);
      $display("test event done");
   endtask

   task automatic t_prio;
      wr_rd(vsir_pkg::OFF_MEM_PRIO, 32'h011FFFFE, 32'h011FFFFE);
      chk("mem_ctl", 32'h1FFFFF, mem_ctl);
      wr_rd(vsir_pkg::OFF_MEM_PRIO, 32'h0000000C, 32'h0000000C);
      chk("mem_ctl", 32'h6, mem_ctl);
      $display("test priority done");
   endtask

   task automatic t_clk;
      wr_rd(vsir_pkg::OFF_CLK_CTRL, 32'h000000C5, 32'h000000C5);
      chk("clk_ctl", 32'h1B, clk_ctl);
      h = en;
      @(posedge pclk);
      chk("encoder_clk_en", {31'h0, ~h}, en);
      wr_rd(vsir_pkg::OFF_CLK_CTRL, 32'h00000008, 32'h00000008);
      chk("clk_ctl", 32'h04, clk_ctl);
      chk("encoder_clk_en", 32'h0, en);
      apb(1'b0, 8'h14, 32'h0);
      chk("pslverr", 32'h1, err);
      chk("unmapped read", 32'h0, rd);
      $display("test clock done");
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard, far beyond the hundred or so cycles needed
   initial begin
      #40000;
      n_mismatch++;
      conclude();
   end

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, irq_src} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      t_reset();
      t_irq();
      t_evt();
      t_prio();
      t_clk();
      conclude();
   end
endmodule
